// ### core/dss_pkg.sv
// Shared constants, types and register map of the dosing stroke scheduler.
package dss_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam longint SECOND_NS = 1_000_000_000;
	localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
	// One slot is the stroke period at full stroke frequency, a hundredth of the stroke period at 1%.
	localparam longint FULL_STROKE_NS = 500_000_000;
	localparam int SLOT_CYCLES = int'(FULL_STROKE_NS / 100 / CLK_PERIOD_NS);
	localparam logic [10:0] MINUTES_PER_DAY = 11'h05A0;
	localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;
	// Currents are in units of 10 uA.
	localparam logic [11:0] CUR_UNDER = 12'h015E;
	localparam logic [11:0] CUR_4MA = 12'h0190;
	localparam logic [11:0] CUR_SPAN_4_20 = 12'h0640;
	localparam logic [11:0] CUR_20MA = 12'h07D0;
	localparam logic [11:0] CUR_OVER = 12'h0802;
	localparam logic [11:0] CUR_FAULT = 12'h09C4;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [6:0] PCT_BURST = 7'h1E;
	localparam logic [9:0] FACTOR_MAX = 10'h03E7;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INFUNC = 8'h04;
	localparam logic [7:0] ADDR_FACTOR = 8'h08;
	localparam logic [7:0] ADDR_POINT1 = 8'h0C;
	localparam logic [7:0] ADDR_POINT2 = 8'h10;
	localparam logic [7:0] ADDR_BATCH = 8'h14;
	localparam logic [7:0] ADDR_START = 8'h18;
	localparam logic [7:0] ADDR_CALIB = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_TIME = 8'h24;
	localparam logic [7:0] ADDR_REMAIN = 8'h28;
	localparam int CTRL_START_BIT = 16;
	localparam int CTRL_STOP_BIT = 17;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
	localparam logic [31:0] INFUNC_RESET = 32'h0000_0021;
	localparam logic [31:0] FACTOR_RESET = 32'h0000_0001;
	localparam logic [31:0] POINT1_RESET = 32'h000F_01F4;
	localparam logic [31:0] POINT2_RESET = 32'h0050_05DC;
	localparam logic [31:0] BATCH_RESET = 32'h0064_0064;
	localparam logic [31:0] START_RESET = 32'h0000_0000;
	localparam logic [31:0] CALIB_RESET = 32'h0000_0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {MODE_MANUAL, MODE_PULSE, MODE_ANALOG, MODE_BATCH, MODE_EXTERNAL}
		dss_mode_type;
	typedef enum logic [1:0] {SIG_4_20, SIG_0_20, SIG_ADJUST} dss_signal_type;
	typedef enum logic [1:0] {PULSE_ONE, PULSE_DIV, PULSE_MUL} dss_pulse_type;
	typedef enum logic [1:0] {BATCH_MANUAL, BATCH_TIMER, BATCH_EXT} dss_batch_type;
	typedef enum logic [2:0] {FN_OFF, FN_PULSE, FN_HALT, FN_BATCH, FN_ANALOG} dss_func_type;

	typedef struct packed {
		logic [13:0] spare;
		logic stop;
		logic start;
		logic [3:0] spare2;
		logic calibrated;
		dss_batch_type batchCtrl;
		logic memoryOn;
		dss_pulse_type pulseMode;
		dss_signal_type signalSel;
		logic burstOnly;
		dss_mode_type mode;
	} dss_ctrl_type;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} dss_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dss_axi_rsp_type;
endpackage

// ### core/dss_scheduler.sv
// Stroke scheduler: analog mapping, pulse strokes, batch starts and register slave.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module dss_scheduler #(
	parameter int SECOND_CYCLES = dss_pkg::SECOND_CYCLES,
	parameter int SLOT_CYCLES = dss_pkg::SLOT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire dss_pkg::dss_axi_req_type axiReq,
	output dss_pkg::dss_axi_rsp_type axiRsp,
	input wire logic [11:0] controlCurrent,
	input wire logic [2:0] inputPins,
	input wire logic enterKey,
	input wire logic messagesShown,
	input wire logic powerLost,
	output logic strokeStart,
	output logic [6:0] motorSpeed,
	output logic batchFinished
);
	function automatic logic [6:0] dssScale(input logic [11:0] num, input logic [11:0] den,
		input logic [6:0] span);
		logic [18:0] prod;
		logic [18:0] quot;
		prod = 19'(num) * 19'(span);
		quot = (den == 12'h000) ? 19'(span) : prod / 19'(den);
		return (quot > 19'(span)) ? span : quot[6:0];
	endfunction

	function automatic logic [31:0] dssMerge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [1:0] dssCount(input logic [2:0] bits);
		return 2'(bits[0]) + 2'(bits[1]) + 2'(bits[2]);
	endfunction

	// Bus slave state.
	dss_pkg::dss_axi_rsp_type rsp_q, rsp_d;
	logic awHeld_q, wHeld_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic [31:0] ctrl_q, inFunc_q, factor_q, point1_q, point2_q, batch_q, start_q, calib_q;

	wire awFire = axiReq.awvalid & rsp_q.awready;
	wire wFire = axiReq.wvalid & rsp_q.wready;
	wire bFire = rsp_q.bvalid & axiReq.bready;
	wire arFire = axiReq.arvalid & rsp_q.arready;
	wire rFire = rsp_q.rvalid & axiReq.rready;
	wire doWrite = awHeld_q & wHeld_q & ~rsp_q.bvalid;
	wire awHeld_d = (awHeld_q | awFire) & ~doWrite;
	wire wHeld_d = (wHeld_q | wFire) & ~doWrite;
	wire writeMapped = (awAddr_q <= dss_pkg::ADDR_CALIB) & (awAddr_q[1:0] == 2'h0);
	wire [31:0] wrMerged = dssMerge(32'h0000_0000, wData_q, wStrb_q);
	wire writeCtrl = doWrite & (awAddr_q == dss_pkg::ADDR_CTRL);
	wire startCmd = writeCtrl & wrMerged[dss_pkg::CTRL_START_BIT];
	wire stopCmd = writeCtrl & wrMerged[dss_pkg::CTRL_STOP_BIT];

	dss_pkg::dss_ctrl_type ctrl;
	assign ctrl = dss_pkg::dss_ctrl_type'(ctrl_q);
	wire [11:0] firstPointCurrent = point1_q[11:0];
	wire [6:0] firstPointFrequency = point1_q[22:16];
	wire [11:0] secondPointCurrent = point2_q[11:0];
	wire [6:0] secondPointFrequency = point2_q[22:16];
	wire [9:0] pulseFactor = factor_q[9:0];

	// Function assignment of each input, decoded once per input.
	logic [2:0] isPulse, isHalt, isBatch, isAnalog;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gFunc
			wire dss_pkg::dss_func_type fn = dss_pkg::dss_func_type'(inFunc_q[3*g +: 3]);
			assign isPulse[g] = (fn == dss_pkg::FN_PULSE);
			assign isHalt[g] = (fn == dss_pkg::FN_HALT);
			assign isBatch[g] = (fn == dss_pkg::FN_BATCH);
			assign isAnalog[g] = (fn == dss_pkg::FN_ANALOG);
		end
	endgenerate

	logic [2:0] inPrev_q;
	wire [2:0] inRise = inputPins & ~inPrev_q;
	wire remoteHalt = |(inputPins & isHalt);
	wire pulseUsable = |isPulse;
	wire extBatchUsable = |isBatch;
	wire [1:0] pulseCount = dssCount(inRise & isPulse);

	// Analog mapping.
	logic running_q, fault_q, stopSeen_q;
	wire isAnalogMode = (ctrl.mode == dss_pkg::MODE_ANALOG);
	wire sel420 = (ctrl.signalSel == dss_pkg::SIG_4_20);
	wire analogOn = isAnalogMode & (|isAnalog) & ~fault_q;
	wire underRange = analogOn & sel420 & (controlCurrent < dss_pkg::CUR_UNDER);
	wire overRange = analogOn & sel420 & (controlCurrent > dss_pkg::CUR_OVER);
	wire faultSet = analogOn & (controlCurrent > dss_pkg::CUR_FAULT);
	wire [6:0] freq420 = (controlCurrent <= dss_pkg::CUR_4MA) ? 7'h00 :
		(controlCurrent >= dss_pkg::CUR_20MA) ? dss_pkg::PCT_FULL :
		dssScale(controlCurrent - dss_pkg::CUR_4MA, dss_pkg::CUR_SPAN_4_20,
		dss_pkg::PCT_FULL);
	wire [6:0] freq020 = dssScale(controlCurrent, dss_pkg::CUR_20MA, dss_pkg::PCT_FULL);
	wire [11:0] adjOffset = controlCurrent - firstPointCurrent;
	wire [11:0] adjSpan = secondPointCurrent - firstPointCurrent;
	wire rising = secondPointFrequency >= firstPointFrequency;
	wire [6:0] adjDelta = dssScale(adjOffset, adjSpan, rising ?
		(secondPointFrequency - firstPointFrequency) :
		(firstPointFrequency - secondPointFrequency));
	wire [6:0] adjInner = rising ? firstPointFrequency + adjDelta :
		firstPointFrequency - adjDelta;
	wire [6:0] adjRaw = (controlCurrent < firstPointCurrent) ? 7'h00 :
		(controlCurrent >= secondPointCurrent) ? secondPointFrequency : adjInner;
	wire [6:0] freqAdj = (adjRaw > dss_pkg::PCT_FULL) ? dss_pkg::PCT_FULL : adjRaw;
	wire [6:0] analogFreq = ~analogOn ? 7'h00 : sel420 ? freq420 :
		(ctrl.signalSel == dss_pkg::SIG_0_20) ? freq020 : freqAdj;

	// Time of day and batch start.
	logic [26:0] secCnt_q;
	logic [5:0] secOfMin_q;
	logic [10:0] timeOfDay_q;
	logic matchPrev_q, batchActive_q;
	logic [15:0] remain_q;
	wire secTick = (secCnt_q == 27'(SECOND_CYCLES - 1));
	wire minTick = secTick & (secOfMin_q == dss_pkg::SECONDS_PER_MINUTE - 6'h01);
	wire isBatchMode = (ctrl.mode == dss_pkg::MODE_BATCH);
	wire timeMatch = (ctrl.batchCtrl == dss_pkg::BATCH_TIMER) &
		(timeOfDay_q == start_q[10:0]);
	wire extTrigger = (ctrl.batchCtrl == dss_pkg::BATCH_EXT) & extBatchUsable &
		(|(inRise & isBatch));
	wire batchTrigger = isBatchMode & running_q & ~batchActive_q & (
		((ctrl.batchCtrl == dss_pkg::BATCH_MANUAL) & enterKey & messagesShown) |
		(timeMatch & ~matchPrev_q) |
		extTrigger);
	wire [15:0] strokeUnits = ctrl.calibrated ? calib_q[15:0] : 16'h0001;

	// Pulse backlog.
	logic [9:0] backlog_q, divCnt_q;
	wire isPulseMode = (ctrl.mode == dss_pkg::MODE_PULSE) & pulseUsable;
	wire [10:0] divSum = 11'(divCnt_q) + 11'(pulseCount);
	// The divider only counts in divide mode, so no stale count survives a mode change.
	wire isDivMode = isPulseMode & (ctrl.pulseMode == dss_pkg::PULSE_DIV);
	wire divHit = (pulseCount != 2'h0) & (divSum >= 11'(pulseFactor));
	wire [9:0] divCnt_d = ~isDivMode ? 10'h000 :
		(divHit ? 10'(divSum - 11'(pulseFactor)) : divSum[9:0]);
	wire [11:0] addMul = 12'(pulseFactor) * 12'(ctrl.memoryOn ? pulseCount : 2'(|pulseCount));
	wire [11:0] addRaw = (ctrl.pulseMode == dss_pkg::PULSE_MUL) ? addMul :
		(ctrl.pulseMode == dss_pkg::PULSE_DIV) ? 12'(divHit) :
		(ctrl.memoryOn ? 12'(pulseCount) : 12'(|pulseCount));
	wire pulseAccept = isPulseMode & (ctrl.memoryOn | backlog_q == 10'h000);
	wire [11:0] pulseAdd = pulseAccept ? addRaw : 12'h000;

	// Stroke engine.
	logic [22:0] slotCnt_q;
	logic [6:0] acc_q;
	wire slotTick = (slotCnt_q == 23'(SLOT_CYCLES - 1));
	wire halted = ~running_q | remoteHalt | overRange | fault_q;
	wire [6:0] demandFreq = isAnalogMode ? analogFreq :
		isBatchMode ? (batchActive_q ? batch_q[22:16] : 7'h00) :
		(isPulseMode & backlog_q != 10'h000) ? dss_pkg::PCT_FULL : 7'h00;
	wire [7:0] accSum = 8'(acc_q) + 8'(demandFreq);
	wire [6:0] accNext = (accSum > 8'(dss_pkg::PCT_FULL)) ? dss_pkg::PCT_FULL : accSum[6:0];
	// The accumulator spaces strokes; lower frequency lengthens the gap, and in analog mode without burstOnly motorSpeed follows it down to PCT_BURST.
	wire fire = ~halted & (demandFreq != 7'h00) & (acc_q == dss_pkg::PCT_FULL);
	wire [6:0] acc_d = (halted | demandFreq == 7'h00 | fire) ? 7'h00 :
		(slotTick ? accNext : acc_q);
	wire [12:0] backlogSum = 13'(backlog_q) - 13'(fire & isPulseMode) + 13'(pulseAdd);
	wire [9:0] backlog_d = ~isPulseMode ? 10'h000 :
		(backlogSum > 13'(dss_pkg::FACTOR_MAX)) ? dss_pkg::FACTOR_MAX :
		backlogSum[9:0];
	wire batchLast = fire & isBatchMode & batchActive_q & (remain_q <= strokeUnits);
	wire [6:0] speed_d = halted ? 7'h00 : (isAnalogMode & ~ctrl.burstOnly &
		analogFreq >= dss_pkg::PCT_BURST) ? analogFreq : dss_pkg::PCT_FULL;

	wire [31:0] statusWord = {6'h00, backlog_q, 2'h0, extBatchUsable, pulseUsable,
		batchActive_q, running_q, fault_q, overRange, underRange, demandFreq};
	logic [31:0] rdWord;
	logic rdMapped;
	always_comb begin
		rdMapped = 1'b1;
		unique case (axiReq.araddr)
			dss_pkg::ADDR_CTRL: rdWord = ctrl_q & 32'h0000_0FFF;
			dss_pkg::ADDR_INFUNC: rdWord = inFunc_q;
			dss_pkg::ADDR_FACTOR: rdWord = factor_q;
			dss_pkg::ADDR_POINT1: rdWord = point1_q;
			dss_pkg::ADDR_POINT2: rdWord = point2_q;
			dss_pkg::ADDR_BATCH: rdWord = batch_q;
			dss_pkg::ADDR_START: rdWord = start_q;
			dss_pkg::ADDR_CALIB: rdWord = calib_q;
			dss_pkg::ADDR_STATUS: rdWord = statusWord;
			dss_pkg::ADDR_TIME: rdWord = {21'h00_0000, timeOfDay_q};
			dss_pkg::ADDR_REMAIN: rdWord = {16'h0000, remain_q};
			default: begin
				rdWord = 32'h0000_0000;
				rdMapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		rsp_d = rsp_q;
		rsp_d.bvalid = doWrite | (rsp_q.bvalid & ~bFire);
		if (doWrite) begin
			rsp_d.bresp = writeMapped ? dss_pkg::RESP_OKAY : dss_pkg::RESP_SLVERR;
		end
		rsp_d.awready = ~awHeld_d & ~rsp_d.bvalid;
		rsp_d.wready = ~wHeld_d & ~rsp_d.bvalid;
		rsp_d.rvalid = arFire | (rsp_q.rvalid & ~rFire);
		if (arFire) begin
			rsp_d.rdata = rdWord;
			rsp_d.rresp = rdMapped ? dss_pkg::RESP_OKAY : dss_pkg::RESP_SLVERR;
		end
		rsp_d.arready = ~rsp_d.rvalid;
	end
	assign axiRsp = rsp_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_q <= '0;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
		end else begin
			rsp_q <= rsp_d;
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			if (awFire) begin
				awAddr_q <= axiReq.awaddr;
			end
			if (wFire) begin
				wData_q <= axiReq.wdata;
				wStrb_q <= axiReq.wstrb;
			end
		end
	end

	// Command bits in the control word act once and are never stored.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= dss_pkg::CTRL_RESET;
			inFunc_q <= dss_pkg::INFUNC_RESET;
			factor_q <= dss_pkg::FACTOR_RESET;
			point1_q <= dss_pkg::POINT1_RESET;
			point2_q <= dss_pkg::POINT2_RESET;
			batch_q <= dss_pkg::BATCH_RESET;
			start_q <= dss_pkg::START_RESET;
			calib_q <= dss_pkg::CALIB_RESET;
		end else if (doWrite) begin
			unique case (awAddr_q)
				dss_pkg::ADDR_CTRL: ctrl_q <= dssMerge(ctrl_q, wData_q, wStrb_q) & 32'h0000_0FFF;
				dss_pkg::ADDR_INFUNC: inFunc_q <= dssMerge(inFunc_q, wData_q, wStrb_q) & 32'h0000_01FF;
				dss_pkg::ADDR_FACTOR: begin
					factor_q <= dssMerge(factor_q, wData_q, wStrb_q) & 32'h0000_03FF;
					if (dssMerge(factor_q, wData_q, wStrb_q) > 32'(dss_pkg::FACTOR_MAX)) begin
						factor_q <= 32'(dss_pkg::FACTOR_MAX);
					end else if (dssMerge(factor_q, wData_q, wStrb_q) == 32'h0000_0000) begin
						factor_q <= dss_pkg::FACTOR_RESET;
					end
				end
				dss_pkg::ADDR_POINT1: point1_q <= dssMerge(point1_q, wData_q, wStrb_q) & 32'h007F_0FFF;
				dss_pkg::ADDR_POINT2: point2_q <= dssMerge(point2_q, wData_q, wStrb_q) & 32'h007F_0FFF;
				dss_pkg::ADDR_BATCH: batch_q <= dssMerge(batch_q, wData_q, wStrb_q) & 32'h007F_FFFF;
				dss_pkg::ADDR_START: start_q <= dssMerge(start_q, wData_q, wStrb_q) & 32'h0000_07FF;
				dss_pkg::ADDR_CALIB: calib_q <= dssMerge(calib_q, wData_q, wStrb_q) & 32'h0000_FFFF;
				default: ;
			endcase
		end
	end

	// Run state; the analog fault needs a stop and then a start to clear.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			running_q <= 1'b0;
			fault_q <= 1'b0;
			stopSeen_q <= 1'b0;
		end else begin
			running_q <= (running_q | startCmd) & ~stopCmd;
			fault_q <= faultSet | (fault_q & ~(startCmd & stopSeen_q));
			stopSeen_q <= fault_q & (stopSeen_q | stopCmd) & ~startCmd;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			secCnt_q <= 27'h000_0000;
			secOfMin_q <= 6'h00;
			timeOfDay_q <= 11'h000;
			matchPrev_q <= 1'b0;
		end else if (powerLost) begin
			secCnt_q <= 27'h000_0000;
			secOfMin_q <= 6'h00;
			timeOfDay_q <= 11'h000;
			matchPrev_q <= 1'b0;
		end else begin
			secCnt_q <= secTick ? 27'h000_0000 : secCnt_q + 27'h000_0001;
			if (secTick) begin
				secOfMin_q <= minTick ? 6'h00 : secOfMin_q + 6'h01;
			end
			if (minTick) begin
				timeOfDay_q <= (timeOfDay_q == dss_pkg::MINUTES_PER_DAY - 11'h001) ? 11'h000 :
					timeOfDay_q + 11'h001;
			end
			matchPrev_q <= timeMatch;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			batchActive_q <= 1'b0;
			remain_q <= 16'h0000;
			batchFinished <= 1'b0;
		end else begin
			if (batchTrigger) begin
				batchActive_q <= 1'b1;
				remain_q <= batch_q[15:0];
				batchFinished <= 1'b0;
			end else if (batchLast | ~isBatchMode) begin
				batchActive_q <= 1'b0;
				remain_q <= 16'h0000;
				batchFinished <= batchLast | (batchFinished & isBatchMode);
			end else if (fire & batchActive_q) begin
				remain_q <= remain_q - strokeUnits;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			inPrev_q <= 3'h0;
			backlog_q <= 10'h000;
			divCnt_q <= 10'h000;
			slotCnt_q <= 23'h00_0000;
			acc_q <= 7'h00;
			strokeStart <= 1'b0;
			motorSpeed <= 7'h00;
		end else begin
			inPrev_q <= inputPins;
			backlog_q <= backlog_d;
			divCnt_q <= (pulseAccept | ~isDivMode) ? divCnt_d : divCnt_q;
			slotCnt_q <= slotTick ? 23'h00_0000 : slotCnt_q + 23'h00_0001;
			acc_q <= acc_d;
			strokeStart <= fire;
			motorSpeed <= speed_d;
		end
	end
endmodule
`default_nettype wire

// ### test/dss_scheduler_checker.sv
// Concurrent checks on the stroke scheduler's ports.
`timescale 1ns/100ps
`default_nettype none
module dss_scheduler_checker #(
	parameter int SECOND_CYCLES = dss_pkg::SECOND_CYCLES,
	parameter int SLOT_CYCLES = dss_pkg::SLOT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire dss_pkg::dss_axi_req_type axiReq,
	input wire dss_pkg::dss_axi_rsp_type axiRsp,
	input wire logic [11:0] controlCurrent,
	input wire logic [2:0] inputPins,
	input wire logic enterKey,
	input wire logic messagesShown,
	input wire logic powerLost,
	input wire logic strokeStart,
	input wire logic [6:0] motorSpeed,
	input wire logic batchFinished
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	stroke_pulse_a: assert property (strokeStart |=> !strokeStart)
		else $error("stroke pulse longer than one cycle");
	speed_range_a: assert property (motorSpeed <= dss_pkg::PCT_FULL)
		else $error("motor speed above full scale");
	bresp_hold_a: assert property (axiRsp.bvalid && !axiReq.bready |=>
		axiRsp.bvalid && $stable(axiRsp.bresp))
		else $error("write response dropped before taken");
	rdata_hold_a: assert property (axiRsp.rvalid && !axiReq.rready |=>
		axiRsp.rvalid && $stable(axiRsp.rdata))
		else $error("read data dropped before taken");
	read_answer_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read answer late");
	arready_low_a: assert property (axiRsp.rvalid |-> !axiRsp.arready)
		else $error("read address accepted while data pending");
	write_answer_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid &&
		axiRsp.wready |-> ##2 axiRsp.bvalid)
		else $error("write response late");
	awready_drop_a: assert property (axiReq.awvalid && axiRsp.awready |=> !axiRsp.awready)
		else $error("write address accepted twice");
endmodule
bind dss_scheduler dss_scheduler_checker #(.SECOND_CYCLES(SECOND_CYCLES),
	.SLOT_CYCLES(SLOT_CYCLES)) checker0 (.sys_clk(sys_clk), .reset_n(reset_n),
	.axiReq(axiReq), .axiRsp(axiRsp), .controlCurrent(controlCurrent),
	.inputPins(inputPins), .enterKey(enterKey), .messagesShown(messagesShown),
	.powerLost(powerLost), .strokeStart(strokeStart), .motorSpeed(motorSpeed),
	.batchFinished(batchFinished));
`default_nettype wire

// ### test/dss_pulse_source.sv
// Model of the regulator and pulse source on the far side of the scheduler.
`timescale 1ns/100ps
`default_nettype none
module dss_pulse_source (
	input wire logic sys_clk,
	output logic [11:0] controlCurrent,
	output logic [2:0] inputPins
);
	initial begin
		controlCurrent = 12'h000;
		inputPins = 3'h0;
	end
	task automatic setCur(input logic [11:0] c);
		@(posedge sys_clk);
		controlCurrent <= c;
	endtask
	task automatic setPin(input int pin, input logic v);
		@(posedge sys_clk);
		inputPins[pin] <= v;
	endtask
	task automatic emit(input int pin, input int n, input int gap);
		repeat (n) begin
			@(posedge sys_clk);
			inputPins[pin] <= 1'b1;
			repeat (2) @(posedge sys_clk);
			inputPins[pin] <= 1'b0;
			repeat (gap) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the stroke scheduler.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic sys_clk = 0;
	logic reset_n = 0;
	dss_pkg::dss_axi_req_type req = '0;
	dss_pkg::dss_axi_rsp_type rsp;
	logic [11:0] controlCurrent;
	logic [2:0] inputPins;
	logic enterKey = 0;
	logic messagesShown = 0;
	logic powerLost = 0;
	logic strokeStart;
	logic [6:0] motorSpeed;
	logic batchFinished;
	logic [31:0] rd;
	logic [1:0] rs;
	int err_total = 0;
	int n_tests = 0;
	int strokes = 0;
	int s0;
	always #5 sys_clk = ~sys_clk;
	// Strokes are counted on the falling edge so that a snapshot taken at a rising edge never races them.
	always @(negedge sys_clk) if (strokeStart === 1'b1) strokes++;
	dss_scheduler #(.SECOND_CYCLES(20), .SLOT_CYCLES(2)) DUT (.sys_clk(sys_clk),
		.reset_n(reset_n), .axiReq(req), .axiRsp(rsp), .controlCurrent(controlCurrent),
		.inputPins(inputPins), .enterKey(enterKey), .messagesShown(messagesShown),
		.powerLost(powerLost), .strokeStart(strokeStart), .motorSpeed(motorSpeed),
		.batchFinished(batchFinished));
	dss_pulse_source SRC (.sys_clk(sys_clk), .controlCurrent(controlCurrent),
		.inputPins(inputPins));
	task automatic results;
		if (err_total == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge sys_clk);
		req.awvalid <= 1;
		req.awaddr <= a;
		req.wvalid <= 1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1;
		while (i < 200) begin
			@(posedge sys_clk);
			i++;
			if (rsp.awready) req.awvalid <= 0;
			if (rsp.wready) req.wvalid <= 0;
			if (rsp.bvalid) begin
				rs = rsp.bresp;
				req.bready <= 0;
				break;
			end
		end
		if (i >= 200) begin
			err_total++;
			results;
		end
	endtask
	task automatic rdReg(input logic [7:0] a);
		int i;
		i = 0;
		@(posedge sys_clk);
		req.arvalid <= 1;
		req.araddr <= a;
		req.rready <= 1;
		while (i < 200) begin
			@(posedge sys_clk);
			i++;
			if (rsp.arready) req.arvalid <= 0;
			if (rsp.rvalid) begin
				rd = rsp.rdata;
				rs = rsp.rresp;
				req.rready <= 0;
				break;
			end
		end
		if (i >= 200) begin
			err_total++;
			results;
		end
	endtask
	task automatic tRegs;
		logic [31:0] rv [8];
		rv = '{dss_pkg::CTRL_RESET, dss_pkg::INFUNC_RESET, dss_pkg::FACTOR_RESET,
			dss_pkg::POINT1_RESET, dss_pkg::POINT2_RESET, dss_pkg::BATCH_RESET,
			dss_pkg::START_RESET, dss_pkg::CALIB_RESET};
		for (int i = 0; i < 8; i++) begin
			rdReg(8'(i * 4));
			chk(rd, rv[i]);
		end
		rdReg(8'h40);
		chk({rd[29:0], rs}, {30'h0, dss_pkg::RESP_SLVERR});
		wrReg(8'h40, 32'h0000_0001);
		chk(32'(rs), 32'(dss_pkg::RESP_SLVERR));
		wrReg(dss_pkg::ADDR_FACTOR, 32'h0000_0000);
		rdReg(dss_pkg::ADDR_FACTOR);
		chk(rd, 32'h0000_0001);
		wrReg(dss_pkg::ADDR_FACTOR, 32'h0000_03E8);
		rdReg(dss_pkg::ADDR_FACTOR);
		chk(rd, 32'h0000_03E7);
	endtask
	task automatic anaCase(input logic [1:0] sig, input logic [11:0] cur,
		input logic [31:0] mask, input logic [31:0] exp);
		wrReg(dss_pkg::ADDR_CTRL, {26'h0, sig, 4'h2} | 32'h0001_0000);
		SRC.setCur(cur);
		repeat (10) @(posedge sys_clk);
		rdReg(dss_pkg::ADDR_STATUS);
		chk(rd & mask, exp);
	endtask
	task automatic tAnalog;
		anaCase(2'h0, 12'h4B0, 32'h0000_01FF, 32'h0000_0032);
		anaCase(2'h0, 12'h190, 32'h0000_01FF, 32'h0000_0000);
		anaCase(2'h0, 12'h7D0, 32'h0000_01FF, 32'h0000_0064);
		anaCase(2'h0, 12'h12C, 32'h0000_0080, 32'h0000_0080);
		anaCase(2'h1, 12'h3E8, 32'h0000_01FF, 32'h0000_0032);
		anaCase(2'h2, 12'h12C, 32'h0000_007F, 32'h0000_0000);
		anaCase(2'h2, 12'h1F4, 32'h0000_007F, 32'h0000_000F);
		anaCase(2'h2, 12'h708, 32'h0000_007F, 32'h0000_0050);
		anaCase(2'h0, 12'h4B0, 32'h0000_01FF, 32'h0000_0032);
		chk(32'(motorSpeed), 32'h0000_0032);
		wrReg(dss_pkg::ADDR_CTRL, 32'h0000_000A);
		repeat (10) @(posedge sys_clk);
		chk(32'(motorSpeed), 32'h0000_0064);
		anaCase(2'h0, 12'h258, 32'h0000_007F, 32'h0000_000C);
		chk(32'(motorSpeed), 32'h0000_0064);
		anaCase(2'h0, 12'h80C, 32'h0000_0100, 32'h0000_0100);
		s0 = strokes;
		repeat (1000) @(posedge sys_clk);
		chk(32'(strokes - s0), 32'h0000_0000);
		anaCase(2'h0, 12'hA28, 32'h0000_0200, 32'h0000_0200);
		SRC.setCur(12'h4B0);
		s0 = strokes;
		repeat (1000) @(posedge sys_clk);
		chk(32'(strokes - s0), 32'h0000_0000);
		wrReg(dss_pkg::ADDR_CTRL, 32'h0002_0002);
		anaCase(2'h0, 12'h4B0, 32'h0000_0200, 32'h0000_0000);
		s0 = strokes;
		repeat (1000) @(posedge sys_clk);
		chk(32'(strokes > s0), 32'h0000_0001);
		wrReg(dss_pkg::ADDR_INFUNC, 32'h0000_00A1);
		SRC.setPin(2, 1'b1);
		@(posedge sys_clk);
		s0 = strokes;
		repeat (200) @(posedge sys_clk);
		chk(32'(strokes - s0), 32'h0000_0000);
		SRC.setPin(2, 1'b0);
		wrReg(dss_pkg::ADDR_INFUNC, 32'h0000_0021);
	endtask
	task automatic pulseCase(input logic mem, input logic [1:0] pm, input logic [9:0] fac,
		input int n, input int gap, input int exp);
		wrReg(dss_pkg::ADDR_FACTOR, {22'h0, fac});
		wrReg(dss_pkg::ADDR_CTRL, {23'h0, mem, pm, 6'h01} | 32'h0001_0000);
		s0 = strokes;
		SRC.emit(0, n, gap);
		repeat (1500) @(posedge sys_clk);
		chk(32'(strokes - s0), 32'(exp));
	endtask
	task automatic tPulse;
		pulseCase(1'b0, 2'h0, 10'h001, 3, 300, 3);
		pulseCase(1'b0, 2'h1, 10'h003, 6, 300, 2);
		pulseCase(1'b0, 2'h2, 10'h003, 1, 0, 3);
		pulseCase(1'b1, 2'h2, 10'h00A, 3, 4, 30);
		pulseCase(1'b0, 2'h2, 10'h00A, 3, 4, 10);
		wrReg(dss_pkg::ADDR_INFUNC, 32'h0000_0020);
		pulseCase(1'b0, 2'h0, 10'h001, 1, 4, 0);
		wrReg(dss_pkg::ADDR_INFUNC, 32'h0000_0021);
	endtask
	task automatic tBatch;
		wrReg(dss_pkg::ADDR_BATCH, 32'h0064_0002);
		wrReg(dss_pkg::ADDR_CTRL, 32'h0001_0003);
		s0 = strokes;
		enterKey <= 1;
		@(posedge sys_clk);
		enterKey <= 0;
		repeat (800) @(posedge sys_clk);
		chk(32'(strokes - s0), 32'h0000_0000);
		messagesShown <= 1;
		enterKey <= 1;
		@(posedge sys_clk);
		enterKey <= 0;
		repeat (1200) @(posedge sys_clk);
		chk(32'(strokes - s0), 32'h0000_0002);
		chk(32'(batchFinished), 32'h0000_0001);
		wrReg(dss_pkg::ADDR_INFUNC, 32'h0000_00E1);
		wrReg(dss_pkg::ADDR_BATCH, 32'h0032_0014);
		wrReg(dss_pkg::ADDR_CTRL, 32'h0001_0403);
		s0 = strokes;
		SRC.emit(2, 1, 0);
		rdReg(dss_pkg::ADDR_STATUS);
		chk(rd & 32'h0000_087F, 32'h0000_0832);
		repeat (1200) @(posedge sys_clk);
		chk(32'(strokes - s0), 32'h0000_0014);
		wrReg(dss_pkg::ADDR_START, 32'h0000_0001);
		wrReg(dss_pkg::ADDR_CALIB, 32'h0000_0005);
		powerLost <= 1;
		wrReg(dss_pkg::ADDR_CTRL, 32'h0001_0A03);
		s0 = strokes;
		repeat (2500) @(posedge sys_clk);
		rdReg(dss_pkg::ADDR_TIME);
		chk(rd, 32'h0000_0000);
		chk(32'(strokes - s0), 32'h0000_0000);
		powerLost <= 0;
		repeat (2000) @(posedge sys_clk);
		chk(32'(strokes - s0), 32'h0000_0004);
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1;
		repeat (2) @(posedge sys_clk);
		tRegs;
		tAnalog;
		tPulse;
		tBatch;
		results;
	end
	initial begin
		repeat (100000) @(posedge sys_clk);
		err_total++;
		results;
	end
endmodule
`default_nettype wire
